// *** hdl/sfmvb_bar_decode.sv ***
// Address match for one virtual function BAR
`timescale 1ns/100ps
module sfmvb_bar_decode
    import sfmvb_pkg::*;
(
    input wire logic usable_in,                  // BAR is legal and on
    input wire logic io_in,                      // BAR claims I/O space
    input wire logic is64_in,                    // BAR spans two slots
    input wire logic [LOG2_W-1:0] log2_in,       // Aperture size exponent
    input wire logic [ADDR_W-1:0] base_in,       // Programmed base
    input wire logic [ADDR_W-1:0] addr_in,       // Request address
    input wire logic req_io_in,                  // Request is I/O
    output logic hit_out                         // Request falls in BAR
);
    logic [ADDR_W-1:0] mask;

    // Power of two aperture: only bits above the size are compared
    always_comb
    begin
        mask = {ADDR_W{1'b1}} << log2_in;
        hit_out = usable_in && (io_in == req_io_in)
            && ((addr_in & mask) == (base_in & mask))
            && (is64_in || (addr_in[ADDR_W-1:32] == '0));
    end
endmodule // sfmvb_bar_decode

// *** hdl/sfmvb_func_map.sv ***
// Virtual function count clamp and first-offset arithmetic
`timescale 1ns/100ps
module sfmvb_func_map
    import sfmvb_pkg::*;
(
    input wire logic [CNT_W-1:0] count_of_function_zero_virtuals_in, // Requested zero VFs
    input wire logic [CNT_W-1:0] count_one_in,   // Requested one VFs
    input wire logic pf1_present_in,             // Function one exists
    output logic [CNT_W-1:0] n0_out,             // Granted zero VFs
    output logic [CNT_W-1:0] n1_out,             // Granted one VFs
    output logic [FN_W-1:0] off0_out,            // Zero first offset
    output logic [FN_W-1:0] off1_out,            // One first offset
    output logic over_out                        // Request was trimmed
);
    logic [CNT_W-1:0] room;

    // Zero gets served first; one only gets what is left of the pool
    always_comb
    begin
        n0_out = (count_of_function_zero_virtuals_in > VF_CNT_MAX) ? VF_CNT_MAX
            : count_of_function_zero_virtuals_in;
        room = VF_CNT_MAX - n0_out;
        n1_out = !pf1_present_in ? '0 : ((count_one_in > room) ? room : count_one_in);
        over_out = (count_of_function_zero_virtuals_in > VF_CNT_MAX)
            || (count_one_in != n1_out);
        off0_out = (n0_out != '0) ? (VF_FN_BASE - PF0_FN) : '0;
        off1_out = (n1_out != '0) ? (PF1_OFF_BIAS + {{(FN_W-CNT_W){1'b0}}, n0_out}) : '0;
    end
endmodule // sfmvb_func_map

// *** hdl/sfmvb_pkg.sv ***
// Constants shared by the virtual function map and VF BAR decode
package sfmvb_pkg;
    localparam int CNT_W = 3;
    localparam int FN_W = 8;
    localparam int VER_W = 4;
    localparam int DEVID_W = 16;
    localparam int PAGE_W = 32;
    localparam int ADDR_W = 64;
    localparam int LOG2_W = 6;
    localparam int NUM_BARS = 6;
    localparam int ROOT_BARS = 2;
    localparam int LAST_BAR = 5;
    localparam logic [CNT_W-1:0] VF_CNT_MAX = 3'h6;
    localparam logic [FN_W-1:0] PF0_FN = 8'h00;
    localparam logic [FN_W-1:0] PF1_FN = 8'h01;
    localparam logic [FN_W-1:0] VF_FN_BASE = 8'h40;
    localparam logic [FN_W-1:0] VF_FN_LAST = 8'h45;
    localparam logic [FN_W-1:0] PF1_OFF_BIAS = 8'h3F;
    localparam logic [LOG2_W-1:0] PAGE_SHIFT = 6'h0C;
    localparam logic [LOG2_W-1:0] LOG2_MIN_STD = 6'h07;
    localparam logic [LOG2_W-1:0] LOG2_MIN_LEG = 6'h04;
    localparam logic [LOG2_W-1:0] LOG2_MAX_32 = 6'h1F;
    localparam logic [LOG2_W-1:0] LOG2_MAX_64 = 6'h26;
    localparam int CLK_NS = 8;
    localparam int FLR_HOLD_NS = 64;
    localparam int FLR_HOLD_CYC = (FLR_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_W = 4;
    typedef enum logic [1:0] {
        SFMVB_IDLE = 2'b00,
        SFMVB_HOLD = 2'b01,
        SFMVB_DONE = 2'b10
    } sfmvb_flr_e;
endpackage

// *** hdl/sfmvb_top.sv ***
// Virtual function numbering, capability fields and VF BAR decode
//
// Function
// - At most six virtual functions in total
// - Physical functions fixed at numbers 0, 1
// - Virtual functions only at numbers 64-69
// - Consecutive numbering, function zero's virtuals first
// - First offset is first VF minus own
// - Function one offset is 63 plus zero's count
// - Each function exposes 4-bit capability version
// - Each function its own 16-bit VF device identifier
// - Bit n means page 2^(n+12) supported
// - Capability for zero, and one if present
// - Per-function reset, endpoint configurations only
// - Endpoint six BARs, root port two
// - 64-bit BAR swallows the following BAR
// - I/O BARs 32-bit, non-prefetchable, legacy only
// - 64-bit up to 256 GB, 32-bit 2 GB
// - Minimum aperture 128 B, legacy 16 B
// - BAR answers only its own space type
// - Prefetchable non-legacy BARs except sixth 64-bit
// - Prefetchable hits flag merge-safe, side-effect free
`timescale 1ns/100ps
module sfmvb_top
    import sfmvb_pkg::*;
#(
    parameter int HOLD_CYC = FLR_HOLD_CYC
) (
    input wire logic ref_clk_in,                 // 125 MHz clock
    input wire logic resetn_in,                  // Sync reset, active low
    input wire logic sriov_enable_in,            // Virtualization on
    input wire logic pf1_present_in,             // Function one exists
    input wire logic endpoint_mode_in,           // Endpoint, not root port
    input wire logic legacy_mode_in,             // Legacy endpoint variant
    input wire logic flr_enable_in,              // Function reset allowed
    input wire logic [CNT_W-1:0] count_of_function_zero_virtuals_in, // Zero VFs
    input wire logic [CNT_W-1:0] count_one_in,   // One VFs
    input wire logic [VER_W-1:0] ver0_in,        // Zero capability version
    input wire logic [VER_W-1:0] ver1_in,        // One capability version
    input wire logic [DEVID_W-1:0] devid0_in,    // Zero VF device id
    input wire logic [DEVID_W-1:0] devid1_in,    // One VF device id
    input wire logic [PAGE_W-1:0] page0_in,      // Zero supported pages
    input wire logic [PAGE_W-1:0] page1_in,      // One supported pages
    input wire logic fn_req_in,                  // Function lookup strobe
    input wire logic [FN_W-1:0] fn_num_in,       // Function number looked up
    input wire logic flr_req_in,                 // Function reset strobe
    input wire logic [FN_W-1:0] flr_func_in,     // Function to reset
    input wire logic [NUM_BARS-1:0] bar_en_in,   // BAR enables
    input wire logic [NUM_BARS-1:0] bar_io_in,   // BAR is I/O
    input wire logic [NUM_BARS-1:0] bar_is64_in, // BAR is 64-bit
    input wire logic [NUM_BARS-1:0] bar_pref_in, // BAR prefetchable
    input wire logic [NUM_BARS*LOG2_W-1:0] bar_log2_in, // Aperture exponents
    input wire logic [NUM_BARS*32-1:0] bar_base_in, // Base words
    input wire logic req_valid_in,               // Decode strobe
    input wire logic [ADDR_W-1:0] req_addr_in,   // Decode address
    input wire logic req_is_io_in,               // Decode is I/O
    output logic [CNT_W-1:0] n0_out,             // Granted zero VFs
    output logic [CNT_W-1:0] n1_out,             // Granted one VFs
    output logic [FN_W-1:0] first_virtual_function_offset0_out, // Zero offset
    output logic [FN_W-1:0] first_virtual_function_offset1_out, // One offset
    output logic vf_over_out,                    // VF request trimmed
    output logic cap0_out,                       // Zero capability present
    output logic cap1_out,                       // One capability present
    output logic [VER_W-1:0] ver0_out,           // Zero version
    output logic [VER_W-1:0] ver1_out,           // One version
    output logic [DEVID_W-1:0] devid0_out,       // Zero VF device id
    output logic [DEVID_W-1:0] devid1_out,       // One VF device id
    output logic [PAGE_W-1:0] page0_out,         // Zero page bits
    output logic [PAGE_W-1:0] page1_out,         // One page bits
    output logic [LOG2_W-1:0] min_page0_out,     // Zero smallest page log2
    output logic [LOG2_W-1:0] min_page1_out,     // One smallest page log2
    output logic fn_ack_out,                     // Lookup answer pulse
    output logic fn_valid_out,                   // Number is populated
    output logic fn_is_vf_out,                   // Number is a VF
    output logic fn_owner_out,                   // Owning function, 1 is one
    output logic [CNT_W-1:0] fn_vf_idx_out,      // VF index in owner
    output logic flr_busy_out,                   // Function in reset
    output logic [FN_W-1:0] flr_func_out,        // Function being reset
    output logic flr_done_out,                   // Reset finished pulse
    output logic flr_reject_out,                 // Reset refused pulse
    output logic [NUM_BARS-1:0] bar_err_out,     // BAR setup illegal
    output logic hit_valid_out,                  // Decode answer pulse
    output logic hit_out,                        // Some BAR hit
    output logic [CNT_W-1:0] hit_bar_out,        // Hit BAR index
    output logic hit_pref_out                    // Merge-safe hit
);
    logic [CNT_W-1:0] n0_c;
    logic [CNT_W-1:0] n1_c;
    logic [FN_W-1:0] off0_c;
    logic [FN_W-1:0] off1_c;
    logic over_c;
    logic [NUM_BARS-1:0] upper_v;
    logic [NUM_BARS-1:0] bad_v;
    logic [NUM_BARS-1:0] usable_v;
    logic [NUM_BARS-1:0] hit_v;
    logic [CNT_W-1:0] n0_q;
    logic [CNT_W-1:0] n1_q;
    logic [FN_W-1:0] off0_q;
    logic [FN_W-1:0] off1_q;
    logic over_q;
    logic cap0_q;
    logic cap1_q;
    logic [VER_W-1:0] ver0_q;
    logic [VER_W-1:0] ver1_q;
    logic [DEVID_W-1:0] devid0_q;
    logic [DEVID_W-1:0] devid1_q;
    logic [PAGE_W-1:0] page0_q;
    logic [PAGE_W-1:0] page1_q;
    logic [LOG2_W-1:0] mpg0_q;
    logic [LOG2_W-1:0] mpg1_q;
    logic fn_ack_q;
    logic [5:0] fn_q;
    sfmvb_flr_e flr_st_q;
    logic [HOLD_W-1:0] hold_q;
    logic [FN_W-1:0] flr_func_q;
    logic flr_done_q;
    logic flr_reject_q;
    logic flr_ok;
    logic [5:0] flr_map;
    logic flr_busy_q;
    logic [NUM_BARS-1:0] bar_err_q;
    logic hit_valid_q;
    logic hit_q;
    logic [CNT_W-1:0] hit_bar_q;
    logic hit_pref_q;

    // Maps a function number to {valid, is_vf, owner, vf index}
    function automatic logic [5:0] fn_decode(input logic [FN_W-1:0] fn,
        input logic [CNT_W-1:0] n0, input logic [CNT_W-1:0] n1, input logic pf1);
        logic [FN_W-1:0] rel;
        logic [CNT_W-1:0] k;
        rel = fn - VF_FN_BASE;
        k = rel[CNT_W-1:0];
        fn_decode = '0;
        if (fn == PF0_FN)
            fn_decode = 6'h20;
        else if (fn == PF1_FN && pf1)
            fn_decode = 6'h28;
        else if (fn >= VF_FN_BASE && fn <= VF_FN_LAST && k < n0)
            fn_decode = {3'b110, k};
        else if (fn >= VF_FN_BASE && fn <= VF_FN_LAST && k < (n0 + n1))
            fn_decode = {3'b111, k - n0};
    endfunction

    // Lowest BAR index that hits; BARs never overlap when set up sanely
    function automatic logic [CNT_W-1:0] first_hit(input logic [NUM_BARS-1:0] v);
        first_hit = '0;
        for (int j = NUM_BARS - 1; j >= 0; j--)
            if (v[j])
                first_hit = CNT_W'(j);
    endfunction

    // Smallest supported page as a log2, zero when no bit is set
    function automatic logic [LOG2_W-1:0] min_page(input logic [PAGE_W-1:0] p);
        min_page = '0;
        for (int j = PAGE_W - 1; j >= 0; j--)
            if (p[j])
                min_page = LOG2_W'(j) + PAGE_SHIFT;
    endfunction

    sfmvb_func_map u_map (
        .count_of_function_zero_virtuals_in(count_of_function_zero_virtuals_in),
        .count_one_in(count_one_in),
        .pf1_present_in(pf1_present_in),
        .n0_out(n0_c),
        .n1_out(n1_c),
        .off0_out(off0_c),
        .off1_out(off1_c),
        .over_out(over_c)
    );

    // Per-BAR legality and address match
    genvar i;
    generate
        for (i = 0; i < NUM_BARS; i++)
        begin : g_bar
            logic [LOG2_W-1:0] lg;
            logic [LOG2_W-1:0] lo;
            logic [ADDR_W-1:0] base;
            assign lg = bar_log2_in[i*LOG2_W +: LOG2_W];
            assign lo = legacy_mode_in ? LOG2_MIN_LEG : LOG2_MIN_STD;
            // previous 64-bit BAR owns this slot
            if (i == 0)
            begin : g_first
                assign upper_v[i] = 1'b0;
            end
            else
            begin : g_next
                assign upper_v[i] = bar_en_in[i-1] && bar_is64_in[i-1];
            end
            if (i == LAST_BAR)
            begin : g_top
                assign base = {32'h0000_0000, bar_base_in[i*32 +: 32]};
            end
            else
            begin : g_low
                assign base = bar_is64_in[i] ? bar_base_in[i*32 +: 64]
                    : {32'h0000_0000, bar_base_in[i*32 +: 32]};
            end
            // root port keeps two slots; I/O legacy 32-bit
            assign bad_v[i] = (!endpoint_mode_in && i >= ROOT_BARS)
                || (bar_io_in[i] && (!legacy_mode_in || bar_is64_in[i] || bar_pref_in[i]))
                || (lg < lo)
                || (lg > (bar_is64_in[i] ? LOG2_MAX_64 : LOG2_MAX_32))
                || (bar_is64_in[i] && i == LAST_BAR)
                || (bar_pref_in[i] && !bar_is64_in[i] && !legacy_mode_in && i != LAST_BAR);
            assign usable_v[i] = sriov_enable_in && bar_en_in[i] && !upper_v[i] && !bad_v[i];
            sfmvb_bar_decode u_dec (
                .usable_in(usable_v[i]),
                .io_in(bar_io_in[i]),
                .is64_in(bar_is64_in[i]),
                .log2_in(lg),
                .base_in(base),
                .addr_in(req_addr_in),
                .req_io_in(req_is_io_in),
                .hit_out(hit_v[i])
            );
        end
    endgenerate

    // granted counts and offsets, held for configuration reads
    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            n0_q <= '0;
            n1_q <= '0;
            off0_q <= '0;
            off1_q <= '0;
            over_q <= 1'b0;
        end
        else
        begin
            n0_q <= sriov_enable_in ? n0_c : '0;
            n1_q <= sriov_enable_in ? n1_c : '0;
            off0_q <= sriov_enable_in ? off0_c : '0;
            off1_q <= sriov_enable_in ? off1_c : '0;
            over_q <= sriov_enable_in && over_c;
        end
    end

    // Capability fields; only the presence flags depend on virtualization being on
    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            cap0_q <= 1'b0;
            cap1_q <= 1'b0;
            ver0_q <= '0;
            ver1_q <= '0;
            devid0_q <= '0;
            devid1_q <= '0;
            page0_q <= '0;
            page1_q <= '0;
            mpg0_q <= '0;
            mpg1_q <= '0;
        end
        else
        begin
            // one capability only when one exists
            cap0_q <= sriov_enable_in;
            cap1_q <= sriov_enable_in && pf1_present_in;
            ver0_q <= ver0_in;
            ver1_q <= ver1_in;
            devid0_q <= devid0_in;
            devid1_q <= devid1_in;
            // page bit n stands for 2^(n+12)
            page0_q <= page0_in;
            page1_q <= page1_in;
            mpg0_q <= min_page(page0_in);
            mpg1_q <= min_page(page1_in);
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            fn_ack_q <= 1'b0;
            fn_q <= '0;
        end
        else
        begin
            fn_ack_q <= fn_req_in;
            if (fn_req_in)
                fn_q <= fn_decode(fn_num_in, n0_q, n1_q, pf1_present_in);
        end
    end

    // reset accepted only in endpoints with the feature on
    assign flr_map = fn_decode(flr_func_in, n0_q, n1_q, pf1_present_in);
    assign flr_ok = flr_enable_in && endpoint_mode_in && flr_map[5];

    // Function reset sequencer; a request during a reset is refused
    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            flr_st_q <= SFMVB_IDLE;
            hold_q <= '0;
            flr_func_q <= '0;
            flr_done_q <= 1'b0;
            flr_reject_q <= 1'b0;
            flr_busy_q <= 1'b0;
        end
        else
        begin
            flr_done_q <= 1'b0;
            flr_reject_q <= flr_req_in && (!flr_ok || flr_st_q != SFMVB_IDLE);
            case (flr_st_q)
                SFMVB_IDLE:
                begin
                    if (flr_req_in && flr_ok)
                    begin
                        flr_st_q <= SFMVB_HOLD;
                        flr_func_q <= flr_func_in;
                        hold_q <= HOLD_W'(HOLD_CYC - 1);
                        flr_busy_q <= 1'b1;
                    end
                end
                SFMVB_HOLD:
                begin
                    if (hold_q == '0)
                        flr_st_q <= SFMVB_DONE;
                    else
                        hold_q <= hold_q - 1'b1;
                end
                SFMVB_DONE:
                begin
                    flr_done_q <= 1'b1;
                    flr_busy_q <= 1'b0;
                    flr_st_q <= SFMVB_IDLE;
                end
                default:
                begin
                    flr_busy_q <= 1'b0;
                    flr_st_q <= SFMVB_IDLE;
                end
            endcase
        end
    end

    // Decode answer one cycle after the strobe
    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            bar_err_q <= '0;
            hit_valid_q <= 1'b0;
            hit_q <= 1'b0;
            hit_bar_q <= '0;
            hit_pref_q <= 1'b0;
        end
        else
        begin
            bar_err_q <= bar_en_in & ~upper_v & bad_v;
            hit_valid_q <= req_valid_in;
            if (req_valid_in)
            begin
                hit_q <= |hit_v;
                hit_bar_q <= first_hit(hit_v);
                // prefetchable memory reads have no side effects
                hit_pref_q <= (|hit_v) && bar_pref_in[first_hit(hit_v)] && !req_is_io_in;
            end
        end
    end

    assign n0_out = n0_q;
    assign n1_out = n1_q;
    assign first_virtual_function_offset0_out = off0_q;
    assign first_virtual_function_offset1_out = off1_q;
    assign vf_over_out = over_q;
    assign cap0_out = cap0_q;
    assign cap1_out = cap1_q;
    assign ver0_out = ver0_q;
    assign ver1_out = ver1_q;
    assign devid0_out = devid0_q;
    assign devid1_out = devid1_q;
    assign page0_out = page0_q;
    assign page1_out = page1_q;
    assign min_page0_out = mpg0_q;
    assign min_page1_out = mpg1_q;
    assign fn_ack_out = fn_ack_q;
    assign {fn_valid_out, fn_is_vf_out, fn_owner_out, fn_vf_idx_out} = fn_q;
    assign flr_busy_out = flr_busy_q;
    assign flr_func_out = flr_func_q;
    assign flr_done_out = flr_done_q;
    assign flr_reject_out = flr_reject_q;
    assign bar_err_out = bar_err_q;
    assign hit_valid_out = hit_valid_q;
    assign hit_out = hit_q;
    assign hit_bar_out = hit_bar_q;
    assign hit_pref_out = hit_pref_q;

    // Checks on the published state
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    a_vf_pool_cap: assert property (({1'b0, n0_q} + {1'b0, n1_q}) <= {1'b0, VF_CNT_MAX})
        else $error("virtual function pool exceeds six");
    a_pf_fixed_num: assert property (fn_ack_q && $past(fn_num_in) == PF1_FN
        && $past(pf1_present_in) |-> fn_valid_out && !fn_is_vf_out && fn_owner_out)
        else $error("function one not at its fixed number");
    a_vf_num_range: assert property (fn_ack_q && fn_is_vf_out
        |-> $past(fn_num_in) >= VF_FN_BASE && $past(fn_num_in) <= VF_FN_LAST)
        else $error("virtual function outside number window");
    a_vf_owner_order: assert property (fn_ack_q && fn_is_vf_out && fn_owner_out
        |-> $past(fn_num_in) >= VF_FN_BASE + {5'h00, $past(n0_q)})
        else $error("function one VF numbered before zero's");
    a_pf0_offset_val: assert property ($past(sriov_enable_in) && $past(n0_c) != '0
        |-> off0_q == VF_FN_BASE)
        else $error("function zero offset wrong");
    a_pf1_offset_val: assert property (n1_q != '0
        |-> off1_q == PF1_OFF_BIAS + {5'h00, n0_q})
        else $error("function one offset wrong");
    a_cap_one_gate: assert property (cap1_q |-> cap0_q && $past(pf1_present_in))
        else $error("function one capability without function one");
    a_flr_gate_mode: assert property (flr_req_in && !(flr_enable_in && endpoint_mode_in)
        |=> flr_reject_q ##1 flr_st_q == SFMVB_IDLE)
        else $error("function reset taken outside endpoint");
    a_io_legacy_only: assert property (hit_valid_q && hit_q && $past(req_is_io_in)
        |-> $past(legacy_mode_in))
        else $error("I/O hit outside legacy endpoint");
    a_space_type_hit: assert property (hit_valid_q && hit_q
        |-> $past(bar_io_in[first_hit(hit_v)]) == $past(req_is_io_in))
        else $error("BAR hit across space type");
    a_upper_half_dead: assert property (hit_valid_q && hit_q
        |-> !$past(upper_v[first_hit(hit_v)]))
        else $error("upper half of 64-bit BAR decoded");
    a_pref_needs_64: assert property (hit_valid_q && hit_pref_q && !$past(legacy_mode_in)
        && hit_bar_q != CNT_W'(LAST_BAR) |-> $past(bar_is64_in[first_hit(hit_v)]))
        else $error("prefetchable 32-bit BAR decoded");
endmodule // sfmvb_top

// *** sim/sfmvb_host_model.sv ***
// Host software model choosing VF BAR layouts
`timescale 1ns/100ps
module sfmvb_host_model (
    input wire logic [31:0] seed_in, // Random draw
    output logic [5:0] log2_out, // Aperture exponent
    output logic [31:0] base_out // Aligned base word
);
    assign log2_out = 6'h0C + {3'h0, seed_in[2:0]};
    // Top bit set keeps the window clear of low probes
    assign base_out = {1'b1, seed_in[30:20], 20'h00000};
endmodule // sfmvb_host_model

// *** sim/sfmvb_top_test.sv ***
// Bench for VF numbering, capability echoes, BAR decode and function reset
`timescale 1ns/100ps
module sfmvb_top_test;
    logic clk, rst_n, fe, fr, flr, rv, io, ack, vl, isvf, own, bsy, dn, rj, hv, ht, hp, cp, ov, cp1;
    logic sen = 1'b1, p1 = 1'b1, ep = 1'b1, lgm = 1'b0;
    logic [2:0] c0, c1, n0, n1, idx, hb;
    logic [3:0] vr, vro;
    logic [5:0] l2, mp, be, bio = 6'h00;
    logic [7:0] fn, o0, o1, ff;
    logic [15:0] dv, dvo;
    logic [31:0] r, sd, pg, pgo, bw;
    logic [63:0] ad;
    logic [31:0] cn [3] = '{32'h0000001A, 32'h00000036, 32'h00000038};
    int mismatches = 0, n_tests = 0, cyc_n = 0, k, e0, e1;
    sfmvb_top #(.HOLD_CYC(2)) sfmvb_top_inst (.ref_clk_in(clk), .resetn_in(rst_n),
        .sriov_enable_in(sen), .pf1_present_in(p1), .endpoint_mode_in(ep),
        .legacy_mode_in(lgm), .flr_enable_in(fe), .count_of_function_zero_virtuals_in(c0),
        .count_one_in(c1), .ver0_in(vr), .ver1_in(vr), .devid0_in(dv), .devid1_in(dv),
        .page0_in(pg), .page1_in(pg), .fn_req_in(fr), .fn_num_in(fn), .flr_req_in(flr),
        .flr_func_in(fn), .bar_en_in(6'h09), .bar_io_in(bio), .bar_is64_in(6'h01),
        .bar_pref_in(6'h09), .bar_log2_in({12'h000, 6'h0C, 12'h000, l2}),
        .bar_base_in({64'h0, 32'h00001000, 32'h0, 32'h0, bw}), .req_valid_in(rv),
        .req_addr_in(ad), .req_is_io_in(io), .n0_out(n0), .n1_out(n1),
        .first_virtual_function_offset0_out(o0), .first_virtual_function_offset1_out(o1),
        .vf_over_out(ov), .cap0_out(cp), .cap1_out(cp1), .ver0_out(vro), .ver1_out(),
        .devid0_out(), .devid1_out(dvo), .page0_out(pgo), .page1_out(), .min_page0_out(mp),
        .min_page1_out(), .fn_ack_out(ack), .fn_valid_out(vl), .fn_is_vf_out(isvf),
        .fn_owner_out(own), .fn_vf_idx_out(idx), .flr_busy_out(bsy), .flr_func_out(ff),
        .flr_done_out(dn), .flr_reject_out(rj), .bar_err_out(be), .hit_valid_out(hv),
        .hit_out(ht), .hit_bar_out(hb), .hit_pref_out(hp));
    sfmvb_host_model sfmvb_host_model_inst (.seed_in(sd), .log2_out(l2), .base_out(bw));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    // Smallest page log2: lowest set bit n stands for 2^(n+12), 0 if none
    function automatic logic [5:0] lowpg(input logic [31:0] p);
        lowpg = 6'h00;
        for (int j = 31; j >= 0; j--) if (p[j]) lowpg = 6'(j + 12);
    endfunction
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("[FAIL] %s exp %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Counts are levels; three edges cover the registered offsets
    task automatic cfg(input logic [31:0] v);
        @(posedge clk) {dv, vr, c1, c0} <= {v[31:16], v[9:0]};
        pg <= v;
        sd <= v;
        e0 = !sen ? 0 : (v[2:0] > 6 ? 6 : v[2:0]);
        e1 = !(sen && p1) ? 0 : (v[5:3] > 6 - e0 ? 6 - e0 : v[5:3]);
        repeat (3) @(posedge clk);
        #1;
        chk("n0", n0, e0);
        chk("n1", n1, e1);
        chk("over", ov, sen && (v[2:0] > 6 || v[5:3] != e1));
        chk("off0", o0, e0 > 0 ? 64 : 0);
        chk("off1", o1, e1 > 0 ? 63 + e0 : 0);
        chk("ver", vro, v[9:6]);
        chk("devid", dvo, v[31:16]);
        chk("page", pgo, v);
        chk("cap", cp, sen);
        chk("cap1", cp1, sen && p1);
        chk("min_page", mp, lowpg(v));
        chk("bar_err", be, (!lgm || bio[3]) ? 6'h08 : 6'h00);
    endtask
    task automatic look(input logic [7:0] f);
        @(posedge clk) fr <= 1'b1;
        fn <= f;
        @(posedge clk) fr <= 1'b0;
        #1;
        k = int'(f) - 64;
        chk("ack", ack, 1'b1);
        chk("valid", vl, f == 0 || (f == 1 && p1) || (f > 63 && k < e0 + e1));
        chk("isvf", isvf & vl, f > 63 && k < e0 + e1);
        chk("owner", own & vl, (f == 1 && p1) || (f > 63 && k >= e0 && k < e0 + e1));
        if (f > 63 && k < e0 + e1) chk("idx", idx, k >= e0 ? k - e0 : k);
    endtask
    task automatic dec(input logic [63:0] a, input logic i, input logic h);
        @(posedge clk) rv <= 1'b1;
        {ad, io} <= {a, i};
        @(posedge clk) rv <= 1'b0;
        #1;
        chk("hit", {hv, ht}, {1'b1, h});
        chk("bar_pref", {hb, hp} & {4{h}}, {3'h0, h});
    endtask
    task automatic frst(input logic e);
        logic ok;
        @(posedge clk) {flr, fe, fn} <= {1'b1, e, 8'h01};
        ok = e && ep;
        @(posedge clk) flr <= 1'b0;
        #1;
        chk("rej_busy", {rj, bsy}, {!ok, ok});
        if (ok) chk("flr_func", ff, 8'h01);
        for (k = 0; ok && dn !== 1'b1 && k < 20; k++) @(posedge clk) #1;
        chk("done", dn, ok);
        chk("flr_len", k, ok ? 3 : 0);
    endtask
    // Clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 6000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    // Corner counts first, then random sweeps
    initial
    begin
        {rst_n, fe, fr, flr, rv, io, c0, c1, vr, dv, pg, sd, fn, ad} = 0;
        r = 32'hA33918CE;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 15; i++)
        begin
            r = nxt(r);
            cfg(i < 3 ? cn[i] : r);
            for (int f = 0; f < 72; f++) if (f < 2 || f > 63) look(8'(f));
            dec({32'h0, bw} + ({32'h0, r} & ((64'h1 << l2) - 1)), 1'b0, 1'b1);
            dec({32'h0, bw}, 1'b1, 1'b0);
            dec({32'h0, bw} + (64'h1 << l2), 1'b0, 1'b0);
            dec(64'h1000, 1'b0, 1'b0);
            $display("test %0d done", i);
        end
        // Feature switches: off, function one absent, legacy, legacy I/O
        for (int m = 0; m < 5; m++)
        begin
            {sen, p1, lgm} <= {m != 1, m != 2, m > 2};
            bio <= {2'h0, m == 4, 3'h0};
            cfg(cn[m % 3]);
            look(8'h01);
            look(8'h40);
            $display("mode %0d done", m);
        end
        frst(1'b0);
        frst(1'b1);
        ep <= 1'b0;
        frst(1'b1);
        give_verdict();
    end
endmodule // sfmvb_top_test
